/* File: rtl/mri_pkg.sv */
// package: reset values, widths and timing counts of the reset and initialization block
`default_nettype none
package mri_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int MIN_RESET_CYCLES = 2;
    localparam int PC_W = 14;
    localparam int SP_W = 10;
    localparam logic [PC_W-1:0] PC_RESET_VAL = 14'h0000;
    localparam logic [SP_W-1:0] SP_RESET_VAL = 10'h3FF;
    localparam logic BRANCH_STATUS_RESET = 1'b1;
    localparam logic STD_LATCH_RESET = 1'b1;
    localparam logic HV_LATCH_RESET = 1'b0;
    localparam logic IE_RESET = 1'b0;
    localparam logic IF_RESET = 1'b0;
    localparam logic IM_RESET = 1'b1;
    localparam logic [3:0] PMR_RESET_VAL = 4'h0;
    localparam logic [3:0] SMR_RESET_VAL = 4'h0;
    localparam logic [2:0] TMA_RESET_VAL = 3'h0;
    localparam logic [3:0] TMB_RESET_VAL = 4'h0;
    localparam logic [10:0] PRESCALER_RESET_VAL = 11'h000;
    localparam logic [7:0] TIMER_RESET_VAL = 8'h00;
    localparam logic [2:0] OCTAL_RESET_VAL = 3'h0;
    typedef enum logic [1:0] {MRI_RESET, MRI_RUN, MRI_STOP} mri_state_t;
endpackage : mri_pkg
`default_nettype wire

/* File: rtl/mri_sync.sv */
// two-flop synchroniser for one pin level
`default_nettype none
module mri_sync (
    input  wire logic clk,       // sampling clock
    input  wire logic rst_n,     // async reset, active low
    input  wire logic rst_val,   // unused; both flops reset to zero whatever its level
    input  wire logic din,       // asynchronous pin level
    output logic      dout       // synchronised level
);
    logic meta_q;
    logic sync_q;
    // first flop feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end
    assign dout = sync_q ^ (rst_val & 1'b0);
endmodule // mri_sync
`default_nettype wire

/* File: rtl/mri_top.sv */
// reset and initialization block of a 4-bit microcontroller core
// Functional notes
// (RULE1) reset held while reset pin high
// (RULE2) external source holds reset two cycles
// (RULE3) source holds reset for oscillator settling
// (RULE4) pc loads 0000, stack pointer 3FF
// (RULE5) branch status flag set to one
// (RULE6) standard latches one, high-voltage latches zero
// (RULE7) interrupt enable, requests clear; masks set
// (RULE8) mode registers clear to zero
// (RULE9) prescaler, counters, reload, octal counter clear
// (RULE10) software initialises working registers after reset
// (RULE11) data memory kept across stop exit
// (RULE12) stop: halt line low, pins high-z
// (RULE13) software sets latches before reading pins
// (RULE14) external-clock serial interrupt: clock pin input
// (RULE15) only reset leaves stop mode
// (RULE16) fetch from reset address after release
// (RULE17) all initial values present when reset ends
`default_nettype none
module mri_top
    import mri_pkg::*;
#(
    parameter int STD_PINS = 32,   // standard output latches
    parameter int HV_PINS  = 26    // high-voltage output latches
) (
    input  wire logic                REF_CLK,          // instruction-cycle clock
    input  wire logic                RSTN,             // power-on reset, active low
    input  wire logic                RESET_PIN,        // external reset pin, active high
    input  wire logic                STOP_REQ,         // stop instruction executed (pulse)
    input  wire logic                IRQ_ANY,          // any interrupt request pending
    input  wire logic                SER_EXT_CLK,      // serial runs on external clock
    input  wire logic                SER_IRQ,          // serial interrupt raised
    input  wire logic [STD_PINS-1:0] STD_LATCH_WR,     // write strobes, standard latches
    input  wire logic [STD_PINS-1:0] STD_LATCH_DIN,    // write data, standard latches
    input  wire logic [HV_PINS-1:0]  HV_LATCH_WR,      // write strobes, high-voltage latches
    input  wire logic [HV_PINS-1:0]  HV_LATCH_DIN,     // write data, high-voltage latches
    output logic                     CORE_RESET,       // core held in reset
    output logic                     FETCH_START,      // first fetch cycle (pulse)
    output logic                     STOP_MODE,        // stop mode active
    output logic                     HALT_LINE,        // halt line, low in stop
    output logic                     HALT_LINE_N,      // complement of halt line
    output logic                     PIN_OE,           // pins may drive; low gives high-z
    output logic                     RAM_HOLD,         // data memory write-protected
    output logic                     SCK_OE,           // serial clock pin output enable
    output logic [PC_W-1:0]          PROGRAM_COUNTER,  // program counter start value
    output logic [SP_W-1:0]          STACK_POINTER,    // stack pointer start value
    output logic                     BRANCH_STATUS_FLAG, // branch status flag
    output logic                     GLOBAL_INTERRUPT_ENABLE, // global interrupt enable
    output logic [3:0]               INTERRUPT_REQUEST_FLAGS, // interrupt request flags
    output logic [3:0]               INTERRUPT_MASK_BITS,     // interrupt mask bits
    output logic [3:0]               PORT_MODE_REGISTER,      // port mode register
    output logic [3:0]               SERIAL_MODE_REGISTER,    // serial mode register
    output logic [2:0]               TIMER_A_MODE_REGISTER,   // timer A mode register
    output logic [3:0]               TIMER_B_MODE_REGISTER,   // timer B mode register
    output logic [10:0]              PRESCALER,               // prescaler
    output logic [7:0]               TIMER_A_COUNTER,         // timer A counter
    output logic [7:0]               TIMER_B_COUNTER,         // timer B counter
    output logic [7:0]               TIMER_B_RELOAD_REGISTER, // timer B reload register
    output logic [2:0]               OCTAL_COUNTER,           // octal counter
    output logic [STD_PINS-1:0]      STD_LATCH,        // standard pin output latches
    output logic [HV_PINS-1:0]       HV_LATCH          // high-voltage pin output latches
);
    ////////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisation
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    logic reset_pin_s;
    // the pin is asynchronous to the instruction clock
    mri_sync u_reset_sync (
        .clk     (REF_CLK),
        .rst_n   (rst_n_q),
        .rst_val (1'b0),
        .din     (RESET_PIN),
        .dout    (reset_pin_s)
    ); // RULE16

    ////////////////////////////////////////////////////////////////////////////////
    // state machine: reset, run, stop
    mri_state_t state_q;
    mri_state_t state_d;
    wire  in_reset = (state_q == MRI_RESET);
    wire  in_stop  = (state_q == MRI_STOP);

    // only the reset pin leaves stop; interrupts are ignored there
    always_comb begin
        state_d = state_q;
        case (state_q)
            MRI_RESET: begin
                if (!reset_pin_s) begin
                    state_d = MRI_RUN; // RULE16
                end
            end
            MRI_RUN: begin
                if (reset_pin_s) begin
                    state_d = MRI_RESET; // RULE1
                end else if (STOP_REQ) begin
                    state_d = MRI_STOP;
                end
            end
            MRI_STOP: begin
                if (reset_pin_s) begin
                    state_d = MRI_RESET; // RULE15
                end
            end
            default: state_d = MRI_RESET;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= MRI_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    logic fetch_q;
    // one-cycle pulse on the first run cycle after reset
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fetch_q <= 1'b0;
        end else begin
            fetch_q <= in_reset && (state_d == MRI_RUN); // RULE16
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status outputs
    assign CORE_RESET  = in_reset; // RULE1
    assign FETCH_START = fetch_q;
    assign STOP_MODE   = in_stop;
    assign HALT_LINE   = !in_stop; // RULE12
    assign HALT_LINE_N = in_stop; // RULE12
    assign PIN_OE      = !in_stop; // RULE12
    // memory is never cleared; it is write-protected through stop and reset
    assign RAM_HOLD    = in_stop || in_reset; // RULE11
    // external serial clock with its interrupt pending: clock pin is input only
    assign SCK_OE      = !in_stop && !(SER_EXT_CLK && SER_IRQ); // RULE14
    wire   irq_unused  = IRQ_ANY & 1'b0; // RULE15

    ////////////////////////////////////////////////////////////////////////////////
    // initial values, loaded every cycle that reset is held so they are ready at release
    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            PROGRAM_COUNTER <= PC_RESET_VAL;
            STACK_POINTER   <= SP_RESET_VAL;
        end else if (in_reset || irq_unused) begin
            PROGRAM_COUNTER <= PC_RESET_VAL; // RULE4 RULE17
            STACK_POINTER   <= SP_RESET_VAL; // RULE4
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            BRANCH_STATUS_FLAG      <= BRANCH_STATUS_RESET;
            GLOBAL_INTERRUPT_ENABLE <= IE_RESET;
            INTERRUPT_REQUEST_FLAGS <= {4{IF_RESET}};
            INTERRUPT_MASK_BITS     <= {4{IM_RESET}};
        end else if (in_reset) begin
            BRANCH_STATUS_FLAG      <= BRANCH_STATUS_RESET; // RULE5
            GLOBAL_INTERRUPT_ENABLE <= IE_RESET; // RULE7
            INTERRUPT_REQUEST_FLAGS <= {4{IF_RESET}}; // RULE7
            INTERRUPT_MASK_BITS     <= {4{IM_RESET}}; // RULE7
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            PORT_MODE_REGISTER    <= PMR_RESET_VAL;
            SERIAL_MODE_REGISTER  <= SMR_RESET_VAL;
            TIMER_A_MODE_REGISTER <= TMA_RESET_VAL;
            TIMER_B_MODE_REGISTER <= TMB_RESET_VAL;
        end else if (in_reset) begin
            PORT_MODE_REGISTER    <= PMR_RESET_VAL; // RULE8
            SERIAL_MODE_REGISTER  <= SMR_RESET_VAL; // RULE8
            TIMER_A_MODE_REGISTER <= TMA_RESET_VAL; // RULE8
            TIMER_B_MODE_REGISTER <= TMB_RESET_VAL; // RULE8
        end
    end

    always_ff @(posedge REF_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            PRESCALER               <= PRESCALER_RESET_VAL;
            TIMER_A_COUNTER         <= TIMER_RESET_VAL;
            TIMER_B_COUNTER         <= TIMER_RESET_VAL;
            TIMER_B_RELOAD_REGISTER <= TIMER_RESET_VAL;
            OCTAL_COUNTER           <= OCTAL_RESET_VAL;
        end else if (in_reset) begin
            PRESCALER               <= PRESCALER_RESET_VAL; // RULE9
            TIMER_A_COUNTER         <= TIMER_RESET_VAL; // RULE9
            TIMER_B_COUNTER         <= TIMER_RESET_VAL; // RULE9
            TIMER_B_RELOAD_REGISTER <= TIMER_RESET_VAL; // RULE9
            OCTAL_COUNTER           <= OCTAL_RESET_VAL; // RULE9 RULE17
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // port output latches: reset levels let every open-drain pin be read as input
    genvar gi;
    generate
        for (gi = 0; gi < STD_PINS; gi++) begin : g_std
            always_ff @(posedge REF_CLK or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    STD_LATCH[gi] <= STD_LATCH_RESET;
                end else if (in_reset) begin
                    STD_LATCH[gi] <= STD_LATCH_RESET; // RULE6
                end else if (STD_LATCH_WR[gi] && !in_stop) begin
                    STD_LATCH[gi] <= STD_LATCH_DIN[gi];
                end
            end
        end
        for (gi = 0; gi < HV_PINS; gi++) begin : g_hv
            always_ff @(posedge REF_CLK or negedge rst_n_q) begin
                if (!rst_n_q) begin
                    HV_LATCH[gi] <= HV_LATCH_RESET;
                end else if (in_reset) begin
                    HV_LATCH[gi] <= HV_LATCH_RESET; // RULE6
                end else if (HV_LATCH_WR[gi] && !in_stop) begin
                    HV_LATCH[gi] <= HV_LATCH_DIN[gi];
                end
            end
        end
    endgenerate
endmodule // mri_top
`default_nettype wire

/* File: sim/mri_bench.sv */
// bench: drives reset pin, stop and serial inputs, checks the initial values
`default_nettype none
module mri_bench
    import mri_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic REF_CLK = 1'b0, RSTN = 1'b0, RESET_PIN, STOP_REQ = 1'b0, IRQ_ANY = 1'b0;
    logic SER_EXT_CLK = 1'b0, SER_IRQ = 1'b0, go = 1'b0, long_hold = 1'b0;
    logic [31:0] STD_LATCH_WR = '0, STD_LATCH_DIN = '0, STD_LATCH;
    logic [25:0] HV_LATCH_WR = '0, HV_LATCH_DIN = '0, HV_LATCH;
    logic CORE_RESET, FETCH_START, STOP_MODE, HALT_LINE, HALT_LINE_N, PIN_OE, RAM_HOLD, SCK_OE;
    logic BRANCH_STATUS_FLAG, GLOBAL_INTERRUPT_ENABLE;
    logic [PC_W-1:0] PROGRAM_COUNTER;
    logic [SP_W-1:0] STACK_POINTER;
    logic [3:0] INTERRUPT_REQUEST_FLAGS, INTERRUPT_MASK_BITS, PORT_MODE_REGISTER;
    logic [3:0] SERIAL_MODE_REGISTER, TIMER_B_MODE_REGISTER;
    logic [2:0] TIMER_A_MODE_REGISTER, OCTAL_COUNTER;
    logic [10:0] PRESCALER;
    logic [7:0] TIMER_A_COUNTER, TIMER_B_COUNTER, TIMER_B_RELOAD_REGISTER;
    int n_fail = 0, num_checks = 0, cyc = 0;

    mri_top dut_u (.*);
    mri_reset_src src_u (.clk(REF_CLK), .go(go), .long_hold(long_hold), .pin(RESET_PIN));

    ////////////////////////////////////////////////////////////////////////////////
    // 20 ns clock
    initial forever #10 REF_CLK = ~REF_CLK;
    // compare one result; four-state match so an unknown never passes
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    // one reset request to the partner, launched on a falling edge
    task automatic pulse_reset(input logic lng);
        @(negedge REF_CLK);
        go <= 1'b1;
        long_hold <= lng;
        @(negedge REF_CLK);
        go <= 1'b0;
    endtask
    // bounded wait for the core reset level
    task automatic wait_core(input logic lvl);
        for (int i = 0; i < 40 && CORE_RESET !== lvl; i++) @(negedge REF_CLK);
        chk(CORE_RESET, lvl, "core reset level");
    endtask
    task automatic chk_init();
        chk({PROGRAM_COUNTER, STACK_POINTER}, {PC_RESET_VAL, SP_RESET_VAL}, "pc sp");
        chk({BRANCH_STATUS_FLAG, GLOBAL_INTERRUPT_ENABLE, INTERRUPT_REQUEST_FLAGS},
            {BRANCH_STATUS_RESET, IE_RESET, {4{IF_RESET}}}, "flags");
        chk(INTERRUPT_MASK_BITS, {4{IM_RESET}}, "masks");
        chk({PORT_MODE_REGISTER, SERIAL_MODE_REGISTER, TIMER_A_MODE_REGISTER},
            {PMR_RESET_VAL, SMR_RESET_VAL, TMA_RESET_VAL}, "modes");
        chk({TIMER_B_MODE_REGISTER, PRESCALER, TIMER_A_COUNTER, TIMER_B_COUNTER},
            {TMB_RESET_VAL, PRESCALER_RESET_VAL, {2{TIMER_RESET_VAL}}}, "timers");
        chk({TIMER_B_RELOAD_REGISTER, OCTAL_COUNTER}, {TIMER_RESET_VAL, OCTAL_RESET_VAL}, "cnt");
        chk({STD_LATCH, HV_LATCH}, {{32{STD_LATCH_RESET}}, {26{HV_LATCH_RESET}}}, "latch");
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // cut a hang short; the whole run needs under a hundred cycles
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(negedge REF_CLK);
        RSTN = 1'b1;
        wait_core(1'b0);
        chk_init();
        // move the latches off their initial values so a reset shows
        STD_LATCH_WR = '1;
        HV_LATCH_WR = '1;
        HV_LATCH_DIN = '1;
        @(negedge REF_CLK);
        STD_LATCH_WR = '0;
        HV_LATCH_WR = '0;
        chk({STD_LATCH, HV_LATCH}, {32'h0000_0000, 26'h3FF_FFFF}, "latch write");
        // shortest legal reset pulse; the fetch pulse stands in the first run cycle
        pulse_reset(1'b0);
        wait_core(1'b1);
        wait_core(1'b0);
        chk_init();
        chk(FETCH_START, 1'b1, "fetch start");
        @(negedge REF_CLK);
        chk(FETCH_START, 1'b0, "fetch one cycle");
        // stop: interrupts and latch writes must not act
        STOP_REQ = 1'b1;
        @(negedge REF_CLK);
        STOP_REQ = 1'b0;
        IRQ_ANY = 1'b1;
        STD_LATCH_WR = '1;
        repeat (6) @(negedge REF_CLK);
        chk(STOP_MODE, 1'b1, "stop kept");
        chk({HALT_LINE, HALT_LINE_N, PIN_OE, RAM_HOLD}, 4'b0101, "stop pins");
        chk(STD_LATCH, {32{STD_LATCH_RESET}}, "latch in stop");
        STD_LATCH_WR = '0;
        IRQ_ANY = 1'b0;
        // leave stop with the settle-length reset
        pulse_reset(1'b1);
        wait_core(1'b1);
        repeat (10) @(negedge REF_CLK);
        chk(CORE_RESET, 1'b1, "reset held");
        wait_core(1'b0);
        chk(STOP_MODE, 1'b0, "stop left");
        chk_init();
        chk(FETCH_START, 1'b1, "fetch after stop");
        chk({HALT_LINE, HALT_LINE_N, PIN_OE, RAM_HOLD, SCK_OE}, 5'h15, "run pins");
        // software writes its read levels into the latches after reset
        STD_LATCH_DIN = 32'hFFFF_0000;
        HV_LATCH_DIN = 26'h300_0000;
        STD_LATCH_WR = '1;
        HV_LATCH_WR = '1;
        @(negedge REF_CLK);
        STD_LATCH_WR = '0;
        HV_LATCH_WR = '0;
        chk({STD_LATCH, HV_LATCH}, {32'hFFFF_0000, 26'h300_0000}, "read levels");
        // external clock alone keeps the pin driven; with its interrupt it is input only
        SER_EXT_CLK = 1'b1;
        @(negedge REF_CLK);
        chk(SCK_OE, 1'b1, "sck driven");
        SER_IRQ = 1'b1;
        repeat (3) @(negedge REF_CLK);
        chk(SCK_OE, 1'b0, "sck input only");
        print_verdict();
    end
endmodule // mri_bench
`default_nettype wire

/* File: sim/mri_checker.sv */
// checker: reset, stop and initial-value properties at the block's ports
`default_nettype none
module mri_checker
    import mri_pkg::*;
#(
    parameter int STD_PINS = 32, // standard latches
    parameter int HV_PINS  = 26  // high-voltage latches
) (
    input wire logic REF_CLK, RSTN, RESET_PIN, SER_EXT_CLK, SER_IRQ, // inputs
    input wire logic CORE_RESET, FETCH_START, STOP_MODE, SCK_OE,     // state
    input wire logic HALT_LINE, HALT_LINE_N, PIN_OE, RAM_HOLD,       // stop side
    input wire logic BRANCH_STATUS_FLAG, GLOBAL_INTERRUPT_ENABLE,    // flags
    input wire logic [PC_W-1:0] PROGRAM_COUNTER,                     // pc
    input wire logic [SP_W-1:0] STACK_POINTER,                       // sp
    input wire logic [3:0] INTERRUPT_REQUEST_FLAGS, INTERRUPT_MASK_BITS, // irq
    input wire logic [3:0] PORT_MODE_REGISTER, SERIAL_MODE_REGISTER, // modes
    input wire logic [3:0] TIMER_B_MODE_REGISTER,                    // mode
    input wire logic [2:0] TIMER_A_MODE_REGISTER, OCTAL_COUNTER,     // mode, count
    input wire logic [10:0] PRESCALER,                               // prescaler
    input wire logic [7:0] TIMER_A_COUNTER, TIMER_B_COUNTER,         // counters
    input wire logic [7:0] TIMER_B_RELOAD_REGISTER,                  // reload
    input wire logic [STD_PINS-1:0] STD_LATCH,                       // std latches
    input wire logic [HV_PINS-1:0]  HV_LATCH                         // hv latches
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    // pin level reaches the core within sync plus state delay
    a_reset_held: assert property (RESET_PIN [*5] |-> CORE_RESET)
        else $error("core not in reset while pin high");
    a_reset_ends: assert property ((!RESET_PIN) [*8] |-> !CORE_RESET)
        else $error("core still in reset after pin low");
    a_fetch_pulse: assert property ($fell(CORE_RESET) |-> ##[0:1]
        (FETCH_START && !STOP_MODE) ##1 !FETCH_START) else $error("fetch pulse wrong");
    // values must be loaded once reset has stood a cycle
    a_pc_sp_init: assert property (CORE_RESET && $past(CORE_RESET) |->
        PROGRAM_COUNTER == PC_RESET_VAL && STACK_POINTER == SP_RESET_VAL)
        else $error("pc or sp not initial");
    a_flag_init: assert property (CORE_RESET && $past(CORE_RESET) |->
        {BRANCH_STATUS_FLAG, GLOBAL_INTERRUPT_ENABLE, INTERRUPT_REQUEST_FLAGS}
        == {BRANCH_STATUS_RESET, IE_RESET, {4{IF_RESET}}} && INTERRUPT_MASK_BITS == {4{IM_RESET}})
        else $error("flags not initial");
    a_mode_timer: assert property (CORE_RESET && $past(CORE_RESET) |->
        {PORT_MODE_REGISTER, SERIAL_MODE_REGISTER, TIMER_A_MODE_REGISTER, TIMER_B_MODE_REGISTER,
        PRESCALER, TIMER_A_COUNTER, TIMER_B_COUNTER, TIMER_B_RELOAD_REGISTER, OCTAL_COUNTER}
        == {PMR_RESET_VAL, SMR_RESET_VAL, TMA_RESET_VAL, TMB_RESET_VAL, PRESCALER_RESET_VAL,
        {3{TIMER_RESET_VAL}}, OCTAL_RESET_VAL}) else $error("modes or timers not initial");
    a_latch_init: assert property (CORE_RESET && $past(CORE_RESET) |->
        STD_LATCH == {STD_PINS{STD_LATCH_RESET}} && HV_LATCH == {HV_PINS{HV_LATCH_RESET}})
        else $error("port latches not initial");
    // stop: pins released, memory write-protected
    a_stop_pins: assert property (STOP_MODE |->
        !HALT_LINE && HALT_LINE_N && !PIN_OE && RAM_HOLD) else $error("stop outputs wrong");
    a_stop_exit: assert property ($fell(STOP_MODE) |-> CORE_RESET)
        else $error("stop left without reset");
    a_ram_reset: assert property (CORE_RESET |-> RAM_HOLD)
        else $error("memory not protected in reset");
    a_run_pins: assert property (!STOP_MODE |-> HALT_LINE && !HALT_LINE_N && PIN_OE)
        else $error("run outputs wrong");
    a_sck_input: assert property ((SER_EXT_CLK && SER_IRQ) [*2] |-> !SCK_OE)
        else $error("serial clock pin still driven");
endmodule // mri_checker
bind mri_top mri_checker #(.STD_PINS(STD_PINS), .HV_PINS(HV_PINS)) chk_u (.*);
`default_nettype wire

/* File: sim/mri_reset_src.sv */
// partner model: external reset source holding the reset pin high for a set time
`default_nettype none
module mri_reset_src
    import mri_pkg::*;
#(
    parameter int SETTLE_CYCLES = 16  // oscillator_settle_time in cycles, plain default
) (
    input  wire logic clk,       // instruction-cycle clock
    input  wire logic go,        // start one reset pulse
    input  wire logic long_hold, // hold for the settle time
    output logic      pin        // reset pin, active high
);
    logic [7:0] cnt_q = 8'h00;
    // never shorter than the minimum: a shorter pulse may be missed by the sync
    always @(negedge clk) begin
        if (go) cnt_q <= long_hold ? 8'(SETTLE_CYCLES) : 8'(MIN_RESET_CYCLES);
        else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
    assign pin = (cnt_q != 8'h00);
endmodule // mri_reset_src
`default_nettype wire
